/* hdl/interrupt_vector_status_unit.sv */
`timescale 1ns/10ps
// Behaviour
// RULE1 - Low register: sources 6..1 in bits 7..2
// RULE2 - Mid register: sources 14..7, read-only, reset zero
// RULE3 - High register: source 15 in bit 0
// RULE4 - USB system vector pair at fffa/fffb
// RULE5 - USB endpoint vector pair at fff8/fff9
// RULE6 - Timer channel 0 vector at fff2/fff3
// RULE7 - Timer channel 1 vector at fff0/fff1
// RULE8 - Timer overflow vector at ffee/ffef
// RULE9 - PS2 port vector at ffec/ffed
// RULE10 - SPI receive vector at ffe4/ffe5
// RULE11 - SPI transmit vector at ffe2/ffe3
// RULE12 - Other slots assigned; priority rises toward reset
// RULE13 - Highest-priority pending source's vector presented
module interrupt_vector_status_unit
    import irq_vector_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Peripheral and core requests, index 1..15 used, bit 0 and reserved 9..11 ignored.
    input  wire logic [15:0] source_events,
    input  wire logic        software_interrupt,
    input  wire logic        reset_request,
    // CPU core vector side.
    input  wire logic        vector_ack,
    output vector_t          vector_out,
    output logic             irq_out
);

    logic [15:0] pending_reg;
    logic [15:0] mask_reg;
    logic [4:0]  win_source;
    logic [15:0] win_high;
    logic [31:0] read_next;
    logic        mapped;
    logic        access;
    logic        wr_status;
    logic        wr_mask;
    logic        ack_clear;
    logic [15:0] ack_bit;
    request_t    req;

    assign access    = psel && penable && !pready;
    assign wr_status = access && pwrite && (paddr == OFS_IRQ_STATUS) && pstrb[0] && pstrb[1];
    assign wr_mask   = access && pwrite && (paddr == OFS_IRQ_MASK);

    // Taking a vector clears the served source's flag, as the core would on stacking.
    assign ack_clear = vector_ack && vector_out.valid && (vector_out.source <= 5'(NUM_SOURCES))
                       && (vector_out.source != SRC_NONE);
    assign ack_bit   = ack_clear ? (16'h0001 << vector_out.source[3:0]) : 16'h0000;

    // A new event in the same cycle as its clear survives: set wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_reg <= {PEND_RESET, PEND_RESET};          // [RULE2]
        end else begin
            pending_reg <= ((pending_reg & ~ack_bit
                             & ~(wr_status ? pwdata[15:0] : 16'h0000))
                            | source_events) & ~RESERVED_SRCS & 16'hfffe;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= MASK_RESET;
        end else if (wr_mask) begin
            if (pstrb[0]) begin
                mask_reg[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                mask_reg[15:8] <= pwdata[15:8];
            end
        end
    end

    // Masked-off sources still show as pending but do not compete for the vector.
    assign req.pending            = pending_reg & mask_reg;
    assign req.software_interrupt = software_interrupt;
    assign req.reset_request      = reset_request;

    priority_pick u_pick (
        .req    (req),
        .source (win_source)
    );

    vector_table u_table (
        .source    (win_source),
        .high_addr (win_high)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_out <= '0;
        end else begin
            vector_out.valid     <= (win_source != SRC_NONE);          // [RULE13]
            vector_out.source    <= win_source;                        // [RULE12]
            vector_out.high_addr <= win_high;
            vector_out.low_addr  <= win_high | 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(pending_reg & mask_reg);
        end
    end

    always_comb begin
        read_next = 32'h0000_0000;
        mapped    = 1'b1;
        unique case (paddr)
            OFS_PEND_LOW:   read_next[7:0] = {pending_reg[6:1], 2'b00};   // [RULE1]
            OFS_PEND_MID:   read_next[7:0] = pending_reg[14:7];           // [RULE2]
            OFS_PEND_HIGH:  read_next[7:0] = {7'h00, pending_reg[15]};    // [RULE3]
            OFS_IRQ_STATUS: read_next[15:0] = pending_reg;
            OFS_IRQ_MASK:   read_next[15:0] = mask_reg;
            OFS_VEC_ACTIVE: read_next = {11'h000, win_source, win_high};
            default:        mapped = 1'b0;
        endcase
    end

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (access) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= pwrite ? 32'h0000_0000 : read_next;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    property p_low_layout;
        @(posedge pclk) disable iff (!presetn)
        (access && !pwrite && paddr == OFS_PEND_LOW) |=>
            (prdata[7:0] == {$past(pending_reg[6:1]), 2'b00});
    endproperty
    a_low_layout: assert property (p_low_layout) else $error("low pending read wrong"); // [RULE1]

    property p_mid_layout;
        @(posedge pclk) disable iff (!presetn)
        (access && !pwrite && paddr == OFS_PEND_MID) |=> (prdata[7:0] == $past(pending_reg[14:7]));
    endproperty
    a_mid_layout: assert property (p_mid_layout) else $error("mid pending read wrong"); // [RULE2]

    property p_high_layout;
        @(posedge pclk) disable iff (!presetn)
        (access && !pwrite && paddr == OFS_PEND_HIGH) |=> (prdata[31:1] == 31'h0);
    endproperty
    a_high_layout: assert property (p_high_layout) else $error("high pending upper bits set"); // [RULE3]

    property p_usb_sys;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h01) |=> (vector_out.high_addr == 16'hfffa && vector_out.low_addr == 16'hfffb);
    endproperty
    a_usb_sys: assert property (p_usb_sys) else $error("usb system vector wrong"); // [RULE4]

    property p_usb_ep;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h02) |=> (vector_out.high_addr == 16'hfff8);
    endproperty
    a_usb_ep: assert property (p_usb_ep) else $error("usb endpoint vector wrong"); // [RULE5]

    property p_timer_ch0;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h05) |=> (vector_out.high_addr == 16'hfff2);
    endproperty
    a_timer_ch0: assert property (p_timer_ch0) else $error("timer ch0 vector wrong"); // [RULE6]

    property p_timer_ch1;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h06) |=> (vector_out.high_addr == 16'hfff0);
    endproperty
    a_timer_ch1: assert property (p_timer_ch1) else $error("timer ch1 vector wrong"); // [RULE7]

    property p_timer_ovf;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h07) |=> (vector_out.high_addr == 16'hffee);
    endproperty
    a_timer_ovf: assert property (p_timer_ovf) else $error("timer overflow vector wrong"); // [RULE8]

    property p_ps2;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h08) |=> (vector_out.high_addr == 16'hffec);
    endproperty
    a_ps2: assert property (p_ps2) else $error("ps2 vector wrong"); // [RULE9]

    property p_spi_rx;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h0c) |=> (vector_out.high_addr == 16'hffe4);
    endproperty
    a_spi_rx: assert property (p_spi_rx) else $error("spi receive vector wrong"); // [RULE10]

    property p_spi_tx;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h0d) |=> (vector_out.high_addr == 16'hffe2);
    endproperty
    a_spi_tx: assert property (p_spi_tx) else $error("spi transmit vector wrong"); // [RULE11]

    property p_reset_top;
        @(posedge pclk) disable iff (!presetn)
        reset_request |=> (vector_out.source == SRC_RESET && vector_out.high_addr == 16'hfffe);
    endproperty
    a_reset_top: assert property (p_reset_top) else $error("reset not highest priority"); // [RULE12]

    property p_highest_wins;
        @(posedge pclk) disable iff (!presetn)
        (!reset_request && !software_interrupt && req.pending[1]) |=>
            (vector_out.source == 5'h01);
    endproperty
    a_highest_wins: assert property (p_highest_wins) else $error("wrong winner"); // [RULE13]

    property p_reset_clear;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (pending_reg == 16'h0000 && !irq_out && !vector_out.valid);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong"); // [RULE2]

    property p_ready_answer;
        @(posedge pclk) disable iff (!presetn)
        access |=> pready;
    endproperty
    a_ready_answer: assert property (p_ready_answer) else $error("late answer"); // [RULE1]

    property p_ready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held"); // [RULE2]

    property p_err_ready;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready"); // [RULE3]

    property p_rdata_idle;
        @(posedge pclk) disable iff (!presetn)
        !pready |-> (prdata == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data"); // [RULE1]

    property p_upper_zero;
        @(posedge pclk) disable iff (!presetn)
        (access && !pwrite && paddr >= OFS_PEND_LOW && paddr <= OFS_PEND_HIGH) |=>
            (prdata[31:8] == 24'h000000);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("status upper bits set"); // [RULE1]

    property p_no_reserved;
        @(posedge pclk) disable iff (!presetn)
        (pending_reg & (RESERVED_SRCS | 16'h0001)) == 16'h0000;
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved pending"); // [RULE12]

    // Set wins: an event of the previous cycle must show whatever was cleared with it.
    property p_event_sets;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> ((pending_reg | ~$past(source_events) | RESERVED_SRCS | 16'h0001) == 16'hffff);
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event lost"); // [RULE2]

    property p_read_only;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr >= OFS_PEND_LOW && paddr <= OFS_PEND_HIGH && !vector_ack)
            |=> ((pending_reg & $past(pending_reg)) == $past(pending_reg));
    endproperty
    a_read_only: assert property (p_read_only) else $error("flags changed by write"); // [RULE2]

    property p_irq_high;
        @(posedge pclk) disable iff (!presetn)
        (|req.pending) |=> irq_out;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("irq missing"); // [RULE13]

    property p_irq_low;
        @(posedge pclk) disable iff (!presetn)
        !(|req.pending) |=> !irq_out;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq without source"); // [RULE13]

    property p_valid_none;
        @(posedge pclk) disable iff (!presetn)
        (win_source == SRC_NONE) |=> !vector_out.valid;
    endproperty
    a_valid_none: assert property (p_valid_none) else $error("valid without source"); // [RULE13]

    property p_pair;
        @(posedge pclk) disable iff (!presetn)
        vector_out.valid |-> (vector_out.low_addr == vector_out.high_addr + 16'h0001);
    endproperty
    a_pair: assert property (p_pair) else $error("low byte not after high"); // [RULE5]

    property p_ext_irq;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h03) |=> (vector_out.high_addr == 16'hfff6);
    endproperty
    a_ext_irq: assert property (p_ext_irq) else $error("irq vector wrong"); // [RULE12]

    property p_pll;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h04) |=> (vector_out.high_addr == 16'hfff4);
    endproperty
    a_pll: assert property (p_pll) else $error("pll vector wrong"); // [RULE12]

    property p_keyboard;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h0e) |=> (vector_out.high_addr == 16'hffe0);
    endproperty
    a_keyboard: assert property (p_keyboard) else $error("keyboard vector wrong"); // [RULE12]

    property p_timebase;
        @(posedge pclk) disable iff (!presetn)
        (win_source == 5'h0f) |=> (vector_out.high_addr == 16'hffde);
    endproperty
    a_timebase: assert property (p_timebase) else $error("timebase vector wrong"); // [RULE12]

    property p_software;
        @(posedge pclk) disable iff (!presetn)
        (software_interrupt && !reset_request) |=>
            (vector_out.source == SRC_SOFTWARE && vector_out.high_addr == 16'hfffc);
    endproperty
    a_software: assert property (p_software) else $error("software vector wrong"); // [RULE12]

    property p_lowest_loses;
        @(posedge pclk) disable iff (!presetn)
        (req.pending[15] && req.pending[5] && !software_interrupt && !reset_request) |=>
            (vector_out.source != 5'h0f);
    endproperty
    a_lowest_loses: assert property (p_lowest_loses) else $error("lowest source won"); // [RULE13]

endmodule // interrupt_vector_status_unit

/* hdl/irq_vector_pkg.sv */
package irq_vector_pkg;

    localparam int          NUM_SOURCES     = 15;
    localparam logic [15:0] OFS_PEND_LOW    = 16'hfe04;
    localparam logic [15:0] OFS_PEND_MID    = 16'hfe05;
    localparam logic [15:0] OFS_PEND_HIGH   = 16'hfe06;
    localparam logic [15:0] OFS_IRQ_STATUS  = 16'hfe10;
    localparam logic [15:0] OFS_IRQ_MASK    = 16'hfe14;
    localparam logic [15:0] OFS_VEC_ACTIVE  = 16'hfe18;
    localparam logic [7:0]  PEND_RESET      = 8'h00;
    localparam logic [15:0] MASK_RESET      = 16'h0000;
    localparam int          PEND_LOW_LSB    = 2;
    localparam int          PEND_MID_FIRST  = 7;
    localparam logic [15:0] RESERVED_SRCS   = 16'h0e00;

    localparam logic [15:0] VEC_TIMEBASE    = 16'hffde;
    localparam logic [15:0] VEC_KEYBOARD    = 16'hffe0;
    localparam logic [15:0] VEC_SPI_TX      = 16'hffe2;
    localparam logic [15:0] VEC_SPI_RX      = 16'hffe4;
    localparam logic [15:0] VEC_RSVD11      = 16'hffe6;
    localparam logic [15:0] VEC_RSVD10      = 16'hffe8;
    localparam logic [15:0] VEC_RSVD9       = 16'hffea;
    localparam logic [15:0] VEC_PS2         = 16'hffec;
    localparam logic [15:0] VEC_TIMER_OVF   = 16'hffee;
    localparam logic [15:0] VEC_TIMER_CH1   = 16'hfff0;
    localparam logic [15:0] VEC_TIMER_CH0   = 16'hfff2;
    localparam logic [15:0] VEC_PLL         = 16'hfff4;
    localparam logic [15:0] VEC_EXT_IRQ     = 16'hfff6;
    localparam logic [15:0] VEC_USB_EP      = 16'hfff8;
    localparam logic [15:0] VEC_USB_SYS     = 16'hfffa;
    localparam logic [15:0] VEC_SOFTWARE    = 16'hfffc;
    localparam logic [15:0] VEC_RESET       = 16'hfffe;

    // Source encoded by priority: 0 none, 1..15 peripheral sources, 16 software, 17 reset.
    localparam logic [4:0]  SRC_NONE        = 5'h00;
    localparam logic [4:0]  SRC_SOFTWARE    = 5'h10;
    localparam logic [4:0]  SRC_RESET       = 5'h11;

    typedef struct packed {
        logic        valid;
        logic [4:0]  source;
        logic [15:0] high_addr;
        logic [15:0] low_addr;
    } vector_t;

    typedef struct packed {
        logic [15:0] pending;
        logic        software_interrupt;
        logic        reset_request;
    } request_t;

endpackage

/* hdl/vector_table.sv */
`timescale 1ns/10ps
module vector_table
    import irq_vector_pkg::*;
(
    // Source code in, vector address out.
    input  wire logic [4:0]  source,
    output logic      [15:0] high_addr
);

    always_comb begin
        unique case (source)
            5'h01: high_addr = VEC_USB_SYS;     // [RULE4]
            5'h02: high_addr = VEC_USB_EP;      // [RULE5]
            5'h03: high_addr = VEC_EXT_IRQ;     // [RULE12]
            5'h04: high_addr = VEC_PLL;         // [RULE12]
            5'h05: high_addr = VEC_TIMER_CH0;   // [RULE6]
            5'h06: high_addr = VEC_TIMER_CH1;   // [RULE7]
            5'h07: high_addr = VEC_TIMER_OVF;   // [RULE8]
            5'h08: high_addr = VEC_PS2;         // [RULE9]
            5'h09: high_addr = VEC_RSVD9;
            5'h0a: high_addr = VEC_RSVD10;
            5'h0b: high_addr = VEC_RSVD11;
            5'h0c: high_addr = VEC_SPI_RX;      // [RULE10]
            5'h0d: high_addr = VEC_SPI_TX;      // [RULE11]
            5'h0e: high_addr = VEC_KEYBOARD;    // [RULE12]
            5'h0f: high_addr = VEC_TIMEBASE;    // [RULE12]
            5'h10: high_addr = VEC_SOFTWARE;    // [RULE12]
            default: high_addr = VEC_RESET;
        endcase
    end

endmodule // vector_table

/* hdl/priority_pick.sv */
`timescale 1ns/10ps
module priority_pick
    import irq_vector_pkg::*;
(
    // Candidate requests.
    input  wire request_t     req,
    // Winning source code.
    output logic      [4:0]   source
);

    // Source 1 is the highest peripheral; reset and software beat all peripherals.
    always_comb begin
        source = SRC_NONE;
        for (int i = NUM_SOURCES; i >= 1; i--) begin
            if (req.pending[i]) begin
                source = 5'(i);
            end
        end
        if (req.software_interrupt) begin
            source = SRC_SOFTWARE;
        end
        if (req.reset_request) begin
            source = SRC_RESET;
        end
    end

endmodule // priority_pick

/* tb/irq_far_side.sv */
`timescale 1ns/10ps
module irq_far_side
    import irq_vector_pkg::*;
(
    // Clock.
    input  wire logic        pclk,
    // Requests toward the unit.
    output logic      [15:0] source_events,
    output logic             software_interrupt,
    output logic             reset_request,
    // Core vector side.
    input  wire vector_t     vector_out,
    output logic             vector_ack
);
    initial begin
        source_events = 16'h0000;
        software_interrupt = 1'b0;
        reset_request = 1'b0;
        vector_ack = 1'b0;
    end

    // A peripheral event is a single-cycle pulse on its line.
    task automatic pulse(input logic [15:0] srcs);
        @(posedge pclk) source_events <= srcs;
        @(posedge pclk) source_events <= 16'h0000;
    endtask

    // Core-level requests are levels held until the core drops them.
    task automatic level(input logic sw, input logic rst);
        @(posedge pclk) software_interrupt <= sw;
        reset_request <= rst;
    endtask

    // The core may take a vector at once or after a few slow cycles.
    task automatic take(input int unsigned delay);
        repeat (delay) @(posedge pclk);
        @(posedge pclk) vector_ack <= 1'b1;
        @(posedge pclk) vector_ack <= 1'b0;
    endtask
endmodule // irq_far_side

/* tb/interrupt_vector_status_unit_tb.sv */
`timescale 1ns/10ps
module interrupt_vector_status_unit_tb
    import irq_vector_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [3:0]  strb = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] source_events;
    logic        software_interrupt;
    logic        reset_request;
    logic        vector_ack;
    vector_t     vector_out;
    logic        irq_out;
    int          n_errors = 0;
    int          checks = 0;
    logic [31:0] q;
    logic        err;
    logic [4:0]  s;
    logic [15:0] hi;
    logic [4:0]  srcs [12] = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd7, 5'd8,
                               5'd12, 5'd13, 5'd14, 5'd15};

    always #2.5 pclk = ~pclk;

    interrupt_vector_status_unit interrupt_vector_status_unit_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .source_events(source_events), .software_interrupt(software_interrupt),
        .reset_request(reset_request), .vector_ack(vector_ack),
        .vector_out(vector_out), .irq_out(irq_out));

    irq_far_side irq_far_side_inst (
        .pclk(pclk), .source_events(source_events),
        .software_interrupt(software_interrupt), .reset_request(reset_request),
        .vector_out(vector_out), .vector_ack(vector_ack));

    task automatic test_done();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Request and qualifiers stay put until pready is sampled high.
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic e);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= wr ? strb : 4'h0;
        @(posedge pclk) penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_errors++;
            test_done();
        end
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0, q, err);
        check(q, exp, what);
    endtask

    // Waits for a given winner, or for no valid vector when asked for SRC_NONE.
    task automatic wait_vec(input logic [4:0] w);
        int n = 0;
        while (!(w == SRC_NONE ? vector_out.valid === 1'b0 :
                 (vector_out.valid === 1'b1 && vector_out.source === w)) && n < 40) begin
            @(posedge pclk);
            n++;
        end
        check({27'h0, vector_out.source}, {27'h0, w}, "vector source");
        if (n >= 40) begin
            n_errors++;
            test_done();
        end
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(OFS_PEND_LOW, 32'h0, "low reset");
        rd_chk(OFS_PEND_MID, 32'h0, "mid reset");
        rd_chk(OFS_PEND_HIGH, 32'h0, "high reset");
        apb(1'b0, 16'hfe20, 32'h0, q, err);
        check({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b1, OFS_IRQ_MASK, 32'h0000ffff, q, err);
        foreach (srcs[i]) begin
            s = srcs[i];
            hi = 16'hfffc - {10'h000, s, 1'b0};
            irq_far_side_inst.pulse(16'h0001 << s);
            wait_vec(s);
            check({16'h0, vector_out.high_addr}, {16'h0, hi}, "vector high");
            check({16'h0, vector_out.low_addr}, {16'h0, hi + 16'h1}, "vector low");
            check({31'h0, irq_out}, 32'h1, "irq level");
            rd_chk(OFS_PEND_LOW, (s <= 6) ? 32'h1 << (s + 1) : 32'h0, "low flag");
            rd_chk(OFS_PEND_MID, (s >= 7 && s <= 14) ? 32'h1 << (s - 7) : 32'h0, "mid flag");
            rd_chk(OFS_PEND_HIGH, {31'h0, s == 5'd15}, "high flag");
            irq_far_side_inst.take(i % 3);
            wait_vec(SRC_NONE);
        end
        irq_far_side_inst.pulse(16'h0e00);
        rd_chk(OFS_PEND_MID, 32'h0, "reserved never pend");
        irq_far_side_inst.pulse(16'h8020);
        wait_vec(5'd5);
        irq_far_side_inst.level(1'b1, 1'b0);
        wait_vec(SRC_SOFTWARE);
        check({16'h0, vector_out.high_addr}, 32'hfffc, "software vector");
        rd_chk(OFS_VEC_ACTIVE, {11'h000, SRC_SOFTWARE, VEC_SOFTWARE}, "active vector");
        irq_far_side_inst.level(1'b1, 1'b1);
        wait_vec(SRC_RESET);
        check({16'h0, vector_out.high_addr}, 32'hfffe, "reset vector");
        irq_far_side_inst.level(1'b0, 1'b0);
        wait_vec(5'd5);
        irq_far_side_inst.take(0);
        wait_vec(5'd15);
        irq_far_side_inst.take(2);
        wait_vec(SRC_NONE);
        apb(1'b1, OFS_IRQ_MASK, 32'h0, q, err);
        irq_far_side_inst.pulse(16'h0008);
        repeat (3) @(posedge pclk);
        check({31'h0, irq_out}, 32'h0, "masked irq");
        check({31'h0, vector_out.valid}, 32'h0, "masked vector");
        rd_chk(OFS_PEND_LOW, 32'h10, "raw pending");
        apb(1'b1, OFS_PEND_LOW, 32'h0, q, err);
        rd_chk(OFS_PEND_LOW, 32'h10, "read only");
        apb(1'b1, OFS_IRQ_MASK, 32'h8, q, err);
        wait_vec(5'd3);
        check({31'h0, irq_out}, 32'h1, "unmasked irq");
        strb = 4'h1;
        apb(1'b1, OFS_IRQ_STATUS, 32'h8, q, err);
        rd_chk(OFS_IRQ_STATUS, 32'h8, "half strobe write ignored");
        strb = 4'hf;
        apb(1'b1, OFS_IRQ_STATUS, 32'h8, q, err);
        wait_vec(SRC_NONE);
        rd_chk(OFS_IRQ_STATUS, 32'h0, "status cleared");
        check({31'h0, irq_out}, 32'h0, "irq cleared");
        test_done();
    end
endmodule // interrupt_vector_status_unit_tb
